// ### pasr_shadow_regs.sv
// Shadow register bank behind one shared address, AXI4-Lite slave
`include "pasr_cfg.svh"
`default_nettype none
// How it works
// - Low three bits of the shared register select one of five shadows.
// - Selector 111 with bit 15 clear updates only the read select.
// - A read returns the shadow named by the stored read select.
// - Bits 15 to 3 of a shadow write are stored into that shadow.
// - A write goes to the shadow named by its own bits 2 to 0.
// - Writing the miscellaneous shadow needs bit 15 set as enable.
// - Auxiliary bit 15 enables external loopback; resets to zero.
// - Auxiliary bit 14 raises the receive length limit to 9720 bytes.
// - Auxiliary bits 13:12 set the gigabit transmit edge rate.
// - Auxiliary bits 5:4 set the fast transmit edge rate.
module pasr_shadow_regs #(
    parameter logic [13:0] STD_LEN = `PASR_STD_LEN
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic ext_loopback,
    output logic rx_ext_len,
    output logic [1:0] gig_edge_rate,
    output logic [1:0] fe_edge_rate,
    output logic [13:0] max_frame_len
);

    localparam logic [4:0][2:0] SHD_CODES = {
        `PASR_CODE_MSC, `PASR_CODE_TST, `PASR_CODE_PWR,
        `PASR_CODE_TEN, `PASR_CODE_AUX
    };

    pasr_pkg::pasr_state_t state_r;
    pasr_pkg::pasr_state_t state_nxt;

    logic wr_fire;
    logic wr_hit;
    logic [2:0] wr_code;
    logic [15:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    // Write decode from the captured address and data

    assign wr_code = state_r.w_data[`PASR_SEL_HI:0];
    assign wr_hit = (state_r.aw_addr == `PASR_SHD_OFS) &&
                    (state_r.w_strb == `PASR_STRB_FULL);
    assign wr_fire = state_r.aw_have && state_r.w_have && !state_r.bvalid;

    ////////////////////////////////////////////////////////////////////////
    // Read mux over the shadows

    always_comb begin
        rd_val = 16'h0000;
        for (int i = 0; i < `PASR_NUM_SHD; i++) begin
            if (state_r.rd_sel == SHD_CODES[i]) begin
                rd_val = {state_r.shd[i], SHD_CODES[i]};
            end
        end
        if (state_r.rd_sel == `PASR_CODE_MSC) begin
            rd_val[`PASR_RDSEL_HI:`PASR_RDSEL_LO] = state_r.rd_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_nxt = state_r;
        if (s_axi_awvalid && state_r.aw_rdy) begin
            state_nxt.aw_have = 1'b1;
            state_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_r.w_rdy) begin
            state_nxt.w_have = 1'b1;
            state_nxt.w_data = s_axi_wdata[15:0];
            state_nxt.w_strb = s_axi_wstrb[1:0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            state_nxt.bvalid = 1'b0;
        end
        if (wr_fire) begin
            state_nxt.aw_have = 1'b0;
            state_nxt.w_have = 1'b0;
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp = (state_r.aw_addr == `PASR_SHD_OFS) ?
                              `PASR_RESP_OKAY : `PASR_RESP_SLVERR;
            if (wr_hit) begin
                if (wr_code == `PASR_CODE_MSC) begin
                    state_nxt.rd_sel = state_r.w_data[
                        `PASR_RDSEL_HI:`PASR_RDSEL_LO];
                    if (state_r.w_data[`PASR_WEN_BIT]) begin
                        state_nxt.shd[`PASR_IDX_MSC] = state_r.w_data[
                            `PASR_DATA_HI:`PASR_STORE_LO];
                    end
                end else begin
                    for (int i = 0; i < `PASR_IDX_MSC; i++) begin
                        if (wr_code == SHD_CODES[i]) begin
                            state_nxt.shd[i] = state_r.w_data[
                                `PASR_DATA_HI:`PASR_STORE_LO];
                        end
                    end
                end
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            state_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state_r.ar_rdy) begin
            state_nxt.rvalid = 1'b1;
            if (s_axi_araddr == `PASR_SHD_OFS) begin
                state_nxt.rdata = rd_val;
                state_nxt.rresp = `PASR_RESP_OKAY;
            end else begin
                state_nxt.rdata = 16'h0000;
                state_nxt.rresp = `PASR_RESP_SLVERR;
            end
        end
        state_nxt.aw_rdy = !state_nxt.aw_have && !state_nxt.bvalid;
        state_nxt.w_rdy = !state_nxt.w_have && !state_nxt.bvalid;
        state_nxt.ar_rdy = !state_nxt.rvalid;
        state_nxt.max_len =
            state_nxt.shd[`PASR_IDX_AUX][`PASR_AUX_JUMBO] ?
            `PASR_JUMBO_LEN : STD_LEN;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_r <= '0;
            state_r.shd[`PASR_IDX_AUX] <= `PASR_AUX_RST;
            state_r.shd[`PASR_IDX_PWR] <= `PASR_PWR_RST;
            state_r.rd_sel <= `PASR_RDSEL_RST;
            state_r.max_len <= STD_LEN;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready = state_r.aw_rdy;
    assign s_axi_wready = state_r.w_rdy;
    assign s_axi_bvalid = state_r.bvalid;
    assign s_axi_bresp = state_r.bresp;
    assign s_axi_arready = state_r.ar_rdy;
    assign s_axi_rvalid = state_r.rvalid;
    assign s_axi_rdata = {16'h0000, state_r.rdata};
    assign s_axi_rresp = state_r.rresp;
    assign ext_loopback = state_r.shd[`PASR_IDX_AUX][`PASR_AUX_LPBK];
    assign rx_ext_len = state_r.shd[`PASR_IDX_AUX][`PASR_AUX_JUMBO];
    assign gig_edge_rate = state_r.shd[`PASR_IDX_AUX][
        `PASR_AUX_GER_HI:`PASR_AUX_GER_LO];
    assign fe_edge_rate = state_r.shd[`PASR_IDX_AUX][
        `PASR_AUX_FER_HI:`PASR_AUX_FER_LO];
    assign max_frame_len = state_r.max_len;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking ast_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    logic aux_wr;
    logic msc_sel_wr;
    logic msc_full_wr;
    logic ten_wr;
    logic ar_hit;
    logic ar_take;
    logic ar_miss;
    logic wr_miss;
    logic wr_part;
    logic wr_unk;

    assign aux_wr = wr_fire && wr_hit && (wr_code == `PASR_CODE_AUX);
    assign ten_wr = wr_fire && wr_hit && (wr_code == `PASR_CODE_TEN);
    assign msc_sel_wr = wr_fire && wr_hit &&
        (wr_code == `PASR_CODE_MSC) && !state_r.w_data[`PASR_WEN_BIT];
    assign msc_full_wr = wr_fire && wr_hit &&
        (wr_code == `PASR_CODE_MSC) && state_r.w_data[`PASR_WEN_BIT];
    assign ar_hit = s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr == `PASR_SHD_OFS);
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign ar_miss = ar_take && (s_axi_araddr != `PASR_SHD_OFS);
    assign wr_miss = wr_fire && (state_r.aw_addr != `PASR_SHD_OFS);
    assign wr_part = wr_fire && (state_r.aw_addr == `PASR_SHD_OFS) &&
        (state_r.w_strb != `PASR_STRB_FULL);
    assign wr_unk = wr_fire && wr_hit && !(wr_code inside {`PASR_CODE_AUX,
        `PASR_CODE_TEN, `PASR_CODE_PWR, `PASR_CODE_TST, `PASR_CODE_MSC});

    AST_AUX_DECODE: assert property (
        aux_wr |=> ext_loopback == $past(state_r.w_data[15]) &&
                   rx_ext_len == $past(state_r.w_data[14]))
        else $error("aux write did not reach aux controls");

    AST_SEL_ONLY: assert property (
        msc_sel_wr |=> state_r.shd == $past(state_r.shd) &&
                       state_r.rd_sel == $past(state_r.w_data[14:12]))
        else $error("select write changed shadow contents");

    AST_READ_SEL: assert property (
        ar_hit && state_r.rd_sel == `PASR_CODE_AUX |=>
            s_axi_rvalid && s_axi_rdata[2:0] == `PASR_CODE_AUX &&
            s_axi_rdata[15:3] == $past(state_r.shd[`PASR_IDX_AUX]))
        else $error("read did not return selected shadow");

    AST_TEN_STORE: assert property (
        ten_wr |=> state_r.shd[`PASR_IDX_TEN] ==
                   $past(state_r.w_data[15:3]) &&
                   state_r.shd[`PASR_IDX_AUX] ==
                   $past(state_r.shd[`PASR_IDX_AUX]))
        else $error("write not directed by its own selector");

    AST_MSC_WEN: assert property (
        msc_full_wr |=> state_r.shd[`PASR_IDX_MSC] ==
                        $past(state_r.w_data[15:3]))
        else $error("enabled misc write not stored");

    AST_LPBK_RST: assert property (
        $rose(rst_b) |-> !ext_loopback && gig_edge_rate == 2'h0 &&
                         fe_edge_rate == 2'h0)
        else $error("aux controls not cleared by reset");

    AST_LEN_LIMIT: assert property (
        $changed(rx_ext_len) |-> max_frame_len ==
            (rx_ext_len ? `PASR_JUMBO_LEN : STD_LEN))
        else $error("frame length limit does not follow aux bit");

    AST_EDGE_RATES: assert property (
        aux_wr |=> gig_edge_rate == $past(state_r.w_data[13:12]) &&
                   fe_edge_rate == $past(state_r.w_data[5:4]))
        else $error("edge rate fields not updated");

    AST_SEL_HOLD: assert property (
        $changed(state_r.rd_sel) |-> $past(msc_sel_wr || msc_full_wr))
        else $error("read select changed without a misc write");

    AST_BRESP: assert property (
        wr_fire |=> s_axi_bvalid ##0 !s_axi_awready [*1])
        else $error("write response missing");

    AST_RST_IDLE: assert property (
        $rose(rst_b) |-> !s_axi_awready && !s_axi_wready &&
            !s_axi_arready && !s_axi_bvalid && !s_axi_rvalid &&
            state_r.rd_sel == `PASR_RDSEL_RST)
        else $error("bus or read select not idle after reset");

    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
            $stable(s_axi_bresp))
        else $error("write response dropped before taken");

    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
            $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before taken");

    AST_AR_BLOCK: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");

    AST_W_BLOCK: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");

    AST_R_LAT: assert property (
        ar_take |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
        else $error("read answer missing or upper half set");

    AST_RD_MISS: assert property (
        ar_miss |=> s_axi_rresp == `PASR_RESP_SLVERR &&
            s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");

    AST_WR_MISS: assert property (
        wr_miss |=> s_axi_bresp == `PASR_RESP_SLVERR &&
            state_r.shd == $past(state_r.shd))
        else $error("unmapped write not refused");

    AST_PART_STRB: assert property (
        wr_part |=> s_axi_bresp == `PASR_RESP_OKAY &&
            state_r.shd == $past(state_r.shd) &&
            state_r.rd_sel == $past(state_r.rd_sel))
        else $error("partial strobe write changed a shadow");

    AST_UNK_CODE: assert property (
        wr_unk |=> state_r.shd == $past(state_r.shd) &&
            state_r.rd_sel == $past(state_r.rd_sel))
        else $error("unknown selector changed a shadow");

    AST_AUX_ONLY: assert property (
        aux_wr |=> state_r.shd[`PASR_IDX_MSC:`PASR_IDX_TEN] ==
            $past(state_r.shd[`PASR_IDX_MSC:`PASR_IDX_TEN]))
        else $error("aux write reached another shadow");

    AST_READ_UNK: assert property (
        ar_hit && !(state_r.rd_sel inside {`PASR_CODE_AUX, `PASR_CODE_TEN,
            `PASR_CODE_PWR, `PASR_CODE_TST, `PASR_CODE_MSC}) |=>
            s_axi_rdata == 32'h00000000)
        else $error("read of unknown shadow not zero");

    AST_READ_MSC: assert property (
        ar_hit && state_r.rd_sel == `PASR_CODE_MSC |=>
            s_axi_rdata[2:0] == `PASR_CODE_MSC &&
            s_axi_rdata[14:12] == `PASR_CODE_MSC)
        else $error("misc read lost its selector fields");

    AST_LEN_VALUE: assert property (
        max_frame_len == (rx_ext_len ? `PASR_JUMBO_LEN : STD_LEN))
        else $error("frame length limit out of step");

    AST_MSC_HOLD: assert property (
        !msc_full_wr |=> state_r.shd[`PASR_IDX_MSC] ==
            $past(state_r.shd[`PASR_IDX_MSC]))
        else $error("misc shadow changed without enable");

    COV_SEL_THEN_READ: cover property (msc_sel_wr ##[1:20] ar_hit);
    COV_AUX_WRITE: cover property (aux_wr);
    COV_MSC_FULL: cover property (msc_full_wr);
    COV_JUMBO: cover property ($rose(rx_ext_len));
    COV_REFUSED: cover property (wr_miss || ar_miss);

endmodule // pasr_shadow_regs
`default_nettype wire

// ### pasr_cfg.svh
// Constants for the shadow register access block
`ifndef PASR_CFG_SVH
`define PASR_CFG_SVH

// Byte address of the shared shadow register
`define PASR_SHD_OFS 8'h30

// Shadow selector codes
`define PASR_CODE_AUX 3'h0
`define PASR_CODE_TEN 3'h1
`define PASR_CODE_PWR 3'h2
`define PASR_CODE_TST 3'h4
`define PASR_CODE_MSC 3'h7

// Storage slots for the shadows
`define PASR_IDX_AUX 0
`define PASR_IDX_TEN 1
`define PASR_IDX_PWR 2
`define PASR_IDX_TST 3
`define PASR_IDX_MSC 4
`define PASR_NUM_SHD 5

// Field positions in the shared register
`define PASR_SEL_HI 2
`define PASR_STORE_LO 3
`define PASR_RDSEL_HI 14
`define PASR_RDSEL_LO 12
`define PASR_WEN_BIT 15
`define PASR_DATA_HI 15

// Positions inside stored bits 15:3
`define PASR_AUX_LPBK 12
`define PASR_AUX_JUMBO 11
`define PASR_AUX_GER_HI 10
`define PASR_AUX_GER_LO 9
`define PASR_AUX_FER_HI 2
`define PASR_AUX_FER_LO 1
`define PASR_MSC_RDSEL_HI 11
`define PASR_MSC_RDSEL_LO 9
`define PASR_MSC_LOW_HI 8

// Reset values of stored bits 15:3 and of the read select
`define PASR_AUX_RST 13'h0080
`define PASR_PWR_RST 13'h000C
`define PASR_RDSEL_RST 3'h0

// Receive frame length limits in bytes
`define PASR_JUMBO_LEN 14'h25F8
`define PASR_STD_LEN 14'h05EE

// AXI responses and full write strobe
`define PASR_RESP_OKAY 2'h0
`define PASR_RESP_SLVERR 2'h2
`define PASR_STRB_FULL 2'h3

`endif

// ### pasr_pkg.sv
// Types for the shadow register access block
`default_nettype none
package pasr_pkg;

    typedef enum logic [1:0] {
        PASR_EDGE_4NS = 2'h0,
        PASR_EDGE_5NS = 2'h1,
        PASR_EDGE_3NS = 2'h2,
        PASR_EDGE_0NS = 2'h3
    } pasr_edge_t;

    typedef struct packed {
        logic aw_have;
        logic w_have;
        logic [7:0] aw_addr;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic aw_rdy;
        logic w_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [15:0] rdata;
        logic [1:0] rresp;
        logic [2:0] rd_sel;
        logic [4:0][12:0] shd;
        logic [13:0] max_len;
    } pasr_state_t;

endpackage
`default_nettype wire

// ### pasr_shadow_regs_tb.sv
// Testbench for the shadow register access block
`include "pasr_cfg.svh"
`default_nettype none
module pasr_shadow_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, gig, fe;
    logic [31:0] rdata;
    logic lpbk, jumbo;
    logic [13:0] mlen;
    int n_fail = 0, n_checks = 0;
    pasr_shadow_regs u_pasr_shadow_regs (.ref_clk(ref_clk), .rst_b(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_loopback(lpbk), .rx_ext_len(jumbo),
        .gig_edge_rate(gig), .fe_edge_rate(fe), .max_frame_len(mlen));
    always #25 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge ref_clk);
            if (awvalid && awready) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "write response");
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] ed,
                      input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {16'h0000, ed}, "read data");
        chk({30'h0, rresp}, {30'h0, er}, "read response");
        @(posedge ref_clk);
    endtask
    task automatic outs(input logic l, input logic j, input logic [1:0] g,
                        input logic [1:0] f);
        chk({12'h0, lpbk, jumbo, gig, fe, mlen},
            {12'h0, l, j, g, f, j ? `PASR_JUMBO_LEN : `PASR_STD_LEN},
            "aux outputs");
    endtask
    task automatic sel_rd(input logic [2:0] c, input logic [15:0] ed);
        wr(`PASR_SHD_OFS, {1'b0, c, 12'h007}, 4'hF, `PASR_RESP_OKAY);
        rd(`PASR_SHD_OFS, ed, `PASR_RESP_OKAY);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done;
    end
    initial begin
        logic [1:0] g;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        outs(1'b0, 1'b0, 2'h0, 2'h0);
        rd(`PASR_SHD_OFS, 16'h0400, `PASR_RESP_OKAY);
        sel_rd(3'h1, 16'h0001);
        sel_rd(3'h2, 16'h0062);
        sel_rd(3'h4, 16'h0004);
        sel_rd(3'h7, 16'h7007);
        sel_rd(3'h3, 16'h0000);
        $display("test reset and select done");
        wr(`PASR_SHD_OFS, 16'hE420, 4'hF, `PASR_RESP_OKAY);
        outs(1'b1, 1'b1, 2'h2, 2'h2);
        sel_rd(3'h0, 16'hE420);
        rd(`PASR_SHD_OFS, 16'hE420, `PASR_RESP_OKAY);
        wr(`PASR_SHD_OFS, 16'hFFFB, 4'hF, `PASR_RESP_OKAY);
        wr(`PASR_SHD_OFS, 16'h1238, 4'h1, `PASR_RESP_OKAY);
        wr(8'h34, 16'h0000, 4'hF, `PASR_RESP_SLVERR);
        rd(8'h34, 16'h0000, `PASR_RESP_SLVERR);
        rd(`PASR_SHD_OFS, 16'hE420, `PASR_RESP_OKAY);
        wr(`PASR_SHD_OFS, 16'h5A59, 4'hF, `PASR_RESP_OKAY);
        outs(1'b1, 1'b1, 2'h2, 2'h2);
        sel_rd(3'h1, 16'h5A59);
        $display("test aux write done");
        wr(`PASR_SHD_OFS, 16'h0FFF, 4'hF, `PASR_RESP_OKAY);
        sel_rd(3'h7, 16'h7007);
        wr(`PASR_SHD_OFS, 16'hF0AF, 4'hF, `PASR_RESP_OKAY);
        rd(`PASR_SHD_OFS, 16'hF0AF, `PASR_RESP_OKAY);
        outs(1'b1, 1'b1, 2'h2, 2'h2);
        $display("test misc write done");
        for (int i = 0; i < 4; i++) begin
            g = i[1:0];
            wr(`PASR_SHD_OFS, {2'b00, g, 4'h4, 2'b00, ~g, 4'h0}, 4'hF,
               `PASR_RESP_OKAY);
            outs(1'b0, 1'b0, g, ~g);
        end
        sel_rd(3'h0, 16'h3400);
        $display("test edge rates done");
        test_done;
    end
endmodule // pasr_shadow_regs_tb
`default_nettype wire
